// File: verilog/ostirq_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Interrupt pin goes low whenever an enabled interrupt is pending.
// - Interrupt pin is open drain: pulls low only, otherwise released.
// - Red and infrared channels are pulsed one after the other, never together.
// - Gap between pulses is 358, 407, 505 or 696 us by pulse width.
// - Rising edge to rising edge is 427, 525, 720 or 1107 us.
// - Up to 32 samples are buffered in an internal FIFO.
// - Finished temperature reading sets ready flag and, if enabled, the pin.
// - In oximetry, almost-full rises when count reaches programmed threshold.
// - Reading the temperature data clears the temperature-ready interrupt.
// - Reading FIFO samples clears the almost-full interrupt.
// - A new sample after read-out lands at the updated read position.
// - In heart-rate mode almost-full rises with one free place left.
// - Heart-rate mode measures only one channel, red or infrared by config.
// - Temperature start bit clears itself when the reading completes.
// - Each active slot gives three bytes, so one data read per enabled slot.
// - Reading the interrupt status clears the flags it reports.
module ostirq_top
    import ostirq_pkg::*;
#(
    parameter int PW_CYC_0      = PW0_CYC,
    parameter int PW_CYC_1      = PW1_CYC,
    parameter int PW_CYC_2      = PW2_CYC,
    parameter int PW_CYC_3      = PW3_CYC,
    parameter int GAP_CYC_0     = GAP0_CYC,
    parameter int GAP_CYC_1     = GAP1_CYC,
    parameter int GAP_CYC_2     = GAP2_CYC,
    parameter int GAP_CYC_3     = GAP3_CYC,
    parameter int TEMP_CYC      = TEMP_CONV_CYC,
    parameter int WAIT_CYC      = SAMPLE_WAIT_CYC
) (
    // Clock and reset
    input  wire logic                 CORE_CLK,
    input  wire logic                 SRST,
    // APB slave
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [7:0]           PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic [31:0]               PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    // Converter results
    input  wire logic [SLOT_BITS-1:0] ADC_VALUE,
    input  wire logic [11:0]          TEMP_VALUE,
    // LED drive
    output logic                      LED_RED,
    output logic                      LED_IR,
    // Open-drain interrupt pin
    output logic                      INT_N_O,
    output logic                      INT_N_OE
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    localparam int TW = 20;

    logic [2:0]             mode_q;
    logic [13:0]            config_q;
    logic [1:0]             int_en_q;
    logic [1:0]             int_flag_q;
    logic                   temp_start_q;
    logic [11:0]            temp_data_q;
    logic [TW-1:0]          temp_cnt_q;
    ostirq_state_t          state_q;
    logic [TW-1:0]          tmr_q;
    logic                   ch_q;         // 0 red slot, 1 infrared slot
    logic                   slot_idx_q;   // Slot index within a sample
    logic [SLOT_BITS-1:0]   slot0_q;
    logic [2*SLOT_BITS-1:0] mem [FIFO_DEPTH];
    logic [4:0]             wr_ptr_q;
    logic [4:0]             rd_ptr_q;
    logic [5:0]             count_q;
    logic                   rd_slot_q;    // Which slot the next data read returns
    logic                   afull_lvl_q;
    logic [31:0]            prdata_q;
    logic                   pslverr_q;

    logic                   acc;
    logic                   wr_acc;
    logic                   rd_acc;
    logic                   oxi;
    logic                   hr;
    logic                   push;
    logic                   pop;
    logic                   last_slot;
    logic                   temp_done;
    logic                   afull_lvl;
    logic [5:0]             thr;
    logic [2*SLOT_BITS-1:0] push_word;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers
    function automatic logic [TW-1:0] pw_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    pw_cycles = TW'(PW_CYC_0);
            2'h1:    pw_cycles = TW'(PW_CYC_1);
            2'h2:    pw_cycles = TW'(PW_CYC_2);
            default: pw_cycles = TW'(PW_CYC_3);
        endcase
    endfunction : pw_cycles

    function automatic logic [TW-1:0] gap_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    gap_cycles = TW'(GAP_CYC_0);
            2'h1:    gap_cycles = TW'(GAP_CYC_1);
            2'h2:    gap_cycles = TW'(GAP_CYC_2);
            default: gap_cycles = TW'(GAP_CYC_3);
        endcase
    endfunction : gap_cycles

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            OFS_INT_STATUS, OFS_INT_ENABLE, OFS_MODE, OFS_CONFIG,
            OFS_FIFO_COUNT, OFS_FIFO_DATA, OFS_TEMP_CTRL, OFS_TEMP_DATA: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////////
    // Bus strobes; zero wait states, side effects only at the access edge
    assign acc     = PSEL & PENABLE & is_mapped(PADDR);
    assign wr_acc  = acc & PWRITE;
    assign rd_acc  = acc & ~PWRITE;
    assign PREADY  = 1'b1;
    assign PRDATA  = prdata_q;
    assign PSLVERR = pslverr_q;
    assign oxi     = (mode_q == MODE_OXI);
    assign hr      = (mode_q == MODE_HR);

    // Control registers written by software
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            mode_q   <= MODE_RST;
            config_q <= CONFIG_RST;
            int_en_q <= INT_EN_RST;
        end else if (wr_acc) begin
            if (PADDR == OFS_MODE)       mode_q   <= PWDATA[2:0];
            if (PADDR == OFS_CONFIG)     config_q <= PWDATA[13:0];
            if (PADDR == OFS_INT_ENABLE) int_en_q <= PWDATA[1:0];
        end
    end

    // Read data is prepared in the setup cycle so it leaves a flip-flop
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            pslverr_q <= ~is_mapped(PADDR);
            prdata_q  <= 32'h0;
            case (PADDR)
                OFS_INT_STATUS: prdata_q <= {30'h0, int_flag_q};
                OFS_INT_ENABLE: prdata_q <= {30'h0, int_en_q};
                OFS_MODE:       prdata_q <= {29'h0, mode_q};
                OFS_CONFIG:     prdata_q <= {18'h0, config_q};
                OFS_FIFO_COUNT: prdata_q <= {26'h0, count_q};
                OFS_FIFO_DATA: begin
                    if (count_q != 6'h0) begin
                        prdata_q <= rd_slot_q
                            ? {8'h0, 6'h0, mem[rd_ptr_q][2*SLOT_BITS-1:SLOT_BITS]}
                            : {8'h0, 6'h0, mem[rd_ptr_q][SLOT_BITS-1:0]};
                    end
                end
                OFS_TEMP_CTRL:  prdata_q <= {31'h0, temp_start_q};
                OFS_TEMP_DATA:  prdata_q <= {20'h0, temp_data_q};
                default:        prdata_q <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Temperature conversion
    assign temp_done = temp_start_q && (temp_cnt_q == TW'(TEMP_CYC - 1));

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            temp_start_q <= 1'b0;
            temp_cnt_q   <= '0;
            temp_data_q  <= 12'h000;
        end else begin
            if (temp_done) begin
                temp_start_q <= 1'b0;
                temp_cnt_q   <= '0;
                temp_data_q  <= TEMP_VALUE;
            end else if (temp_start_q) begin
                temp_cnt_q <= temp_cnt_q + 1'b1;
            end else if (wr_acc && PADDR == OFS_TEMP_CTRL && PWDATA[BIT_TEMP_START]) begin
                temp_start_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slot sequencer: pulse, gap, next channel; a waiting period ends a sample
    // single channel in heart-rate mode
    assign last_slot = hr | (slot_idx_q == 1'b1);

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            state_q    <= ST_IDLE;
            tmr_q      <= '0;
            ch_q       <= 1'b0;
            slot_idx_q <= 1'b0;
            slot0_q    <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (oxi || hr) begin
                        state_q    <= ST_PULSE;
                        tmr_q      <= '0;
                        slot_idx_q <= 1'b0;
                        ch_q       <= hr ? config_q[BIT_HR_IR] : 1'b0;
                    end
                end
                ST_PULSE: begin
                    if (tmr_q == pw_cycles(config_q[POS_PW +: 2]) - 1'b1) begin
                        state_q <= ST_GAP;
                        tmr_q   <= '0;
                        if (!last_slot) slot0_q <= ADC_VALUE;
                    end else begin
                        tmr_q <= tmr_q + 1'b1;
                    end
                end
                ST_GAP: begin
                    if (tmr_q == gap_cycles(config_q[POS_PW +: 2]) - 1'b1) begin
                        tmr_q <= '0;
                        if (!(oxi || hr)) begin
                            state_q <= ST_IDLE;
                        end else if (last_slot) begin
                            state_q <= ST_WAIT;
                        end else begin
                            state_q    <= ST_PULSE;
                            slot_idx_q <= 1'b1;
                            ch_q       <= 1'b1;
                        end
                    end else begin
                        tmr_q <= tmr_q + 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (tmr_q == TW'(WAIT_CYC - 1)) begin
                        state_q <= ST_IDLE;
                        tmr_q   <= '0;
                    end else begin
                        tmr_q <= tmr_q + 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // LED drive follows the pulse state of the active channel
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            LED_RED <= 1'b0;
            LED_IR  <= 1'b0;
        end else begin
            LED_RED <= (state_q == ST_PULSE) && !ch_q;
            LED_IR  <= (state_q == ST_PULSE) && ch_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample FIFO; a sample is pushed at the end of its last pulse
    assign push = (state_q == ST_PULSE) && last_slot && (count_q != 6'(FIFO_DEPTH))
                  && (tmr_q == pw_cycles(config_q[POS_PW +: 2]) - 1'b1);
    // pop after the last slot word of a sample is read
    assign pop  = rd_acc && PADDR == OFS_FIFO_DATA && count_q != 6'h0
                  && (hr || rd_slot_q);
    assign push_word = hr ? {{SLOT_BITS{1'b0}}, ADC_VALUE} : {ADC_VALUE, slot0_q};

    // thirty-two entry storage; full FIFO drops new samples
    always_ff @(posedge CORE_CLK) begin
        if (push) mem[wr_ptr_q] <= push_word;
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            wr_ptr_q  <= 5'h00;
            rd_ptr_q  <= 5'h00;
            count_q   <= 6'h00;
            rd_slot_q <= 1'b0;
        end else begin
            // write pointer meets updated read pointer
            if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)  rd_ptr_q <= rd_ptr_q + 1'b1;
            if (push && !pop)      count_q <= count_q + 1'b1;
            else if (pop && !push) count_q <= count_q - 1'b1;
            if (rd_acc && PADDR == OFS_FIFO_DATA && count_q != 6'h0 && !hr)
                rd_slot_q <= ~rd_slot_q;
            else if (hr)
                rd_slot_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Almost-full level; a threshold of zero is taken as a full FIFO
    assign thr = (config_q[POS_THR +: 6] == 6'h0) ? 6'(FIFO_DEPTH) : config_q[POS_THR +: 6];
    // one free place in heart-rate mode
    assign afull_lvl = oxi ? (count_q >= thr) : hr ? (count_q >= HR_AFULL_LEVEL) : 1'b0;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) afull_lvl_q <= 1'b0;
        else      afull_lvl_q <= afull_lvl;
    end

    // Sticky flags; a new event in the clearing cycle wins over the clear
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            int_flag_q <= 2'h0;
        end else begin
            if (rd_acc && PADDR == OFS_INT_STATUS) int_flag_q <= 2'h0;
            if (rd_acc && PADDR == OFS_TEMP_DATA) int_flag_q[BIT_TEMP_RDY] <= 1'b0;
            if (rd_acc && PADDR == OFS_FIFO_DATA) int_flag_q[BIT_AFULL] <= 1'b0;
            if (temp_done) int_flag_q[BIT_TEMP_RDY] <= 1'b1;
            if (afull_lvl && !afull_lvl_q) int_flag_q[BIT_AFULL] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pin: only ever pulled low, never driven high
    // open drain
    assign INT_N_O = 1'b0;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            INT_N_OE <= 1'b0;
        end else begin
            INT_N_OE <= |(int_flag_q & int_en_q);
        end
    end

endmodule : ostirq_top

// File: verilog/ostirq_pkg.sv
// Shared constants for the optical sample sequencer
package ostirq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // APB register byte offsets
    localparam logic [7:0] OFS_INT_STATUS = 8'h00;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h04;
    localparam logic [7:0] OFS_MODE       = 8'h08;
    localparam logic [7:0] OFS_CONFIG     = 8'h0C;
    localparam logic [7:0] OFS_FIFO_COUNT = 8'h10;
    localparam logic [7:0] OFS_FIFO_DATA  = 8'h14;
    localparam logic [7:0] OFS_TEMP_CTRL  = 8'h18;
    localparam logic [7:0] OFS_TEMP_DATA  = 8'h1C;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_AFULL      = 0;   // Status and enable
    localparam int BIT_TEMP_RDY   = 1;   // Status and enable
    localparam int BIT_TEMP_START = 0;   // Temperature control
    localparam int BIT_HR_IR      = 2;   // Config: heart-rate channel
    localparam int POS_PW         = 0;   // Config: pulse-width select [1:0]
    localparam int POS_THR        = 8;   // Config: almost-full threshold [13:8]

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and encodings
    localparam logic [2:0]  MODE_RST    = 3'h0;
    localparam logic [2:0]  MODE_HR     = 3'h2;
    localparam logic [2:0]  MODE_OXI    = 3'h3;
    localparam logic [13:0] CONFIG_RST  = 14'h1000;  // Threshold 16, 69 us, red
    localparam logic [1:0]  INT_EN_RST  = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // FIFO geometry
    localparam int FIFO_DEPTH = 32;
    localparam int SLOT_BITS  = 18;    // Converter result per slot
    localparam int WORD_BITS  = 24;    // Three bytes per slot
    localparam logic [5:0] HR_AFULL_LEVEL = 6'h1F;   // One free place left

    ////////////////////////////////////////////////////////////////////////////
    // Timing: figures in microseconds, counts at the core clock
    localparam int CLK_MHZ  = 25;
    localparam int PW0_US   = 69;
    localparam int PW1_US   = 118;
    localparam int PW2_US   = 215;
    localparam int PW3_US   = 411;
    localparam int GAP0_US  = 358;
    localparam int GAP1_US  = 407;
    localparam int GAP2_US  = 505;
    localparam int GAP3_US  = 696;
    localparam int PW0_CYC  = PW0_US * CLK_MHZ;
    localparam int PW1_CYC  = PW1_US * CLK_MHZ;
    localparam int PW2_CYC  = PW2_US * CLK_MHZ;
    localparam int PW3_CYC  = PW3_US * CLK_MHZ;
    localparam int GAP0_CYC = GAP0_US * CLK_MHZ;
    localparam int GAP1_CYC = GAP1_US * CLK_MHZ;
    localparam int GAP2_CYC = GAP2_US * CLK_MHZ;
    localparam int GAP3_CYC = GAP3_US * CLK_MHZ;
    localparam int TEMP_CONV_CYC   = 1000;
    localparam int SAMPLE_WAIT_CYC = 1000;

    typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_GAP, ST_WAIT} ostirq_state_t;

endpackage : ostirq_pkg

// File: tb/ostirq_sense_model.sv
`timescale 1ns/1ps
module ostirq_sense_model
    import ostirq_pkg::*;
#(
    parameter logic [11:0] TEMP_CODE = 12'h5A3
) (
    // Clock, reset and LED drive
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 led_red,
    input  wire logic                 led_ir,
    // Open-drain interrupt pin
    input  wire logic                 int_n_o,
    input  wire logic                 int_n_oe,
    output logic                      int_pin,
    // Converter outputs
    output logic [SLOT_BITS-1:0]      adc_value,
    output logic [11:0]               temp_value
);
    logic [16:0] n_q;
    logic        red_q;
    logic        ir_q;
    // Pulse counter, so each word names its pulse and channel
    always_ff @(posedge clk) begin
        red_q <= led_red;
        ir_q  <= led_ir;
        if (srst) begin
            n_q <= 17'h0;
        end else if ((led_red && !red_q) || (led_ir && !ir_q)) begin
            n_q <= n_q + 17'h1;
        end
    end
    // Value is only meaningful while a LED is lit; otherwise garbage
    always_comb begin
        adc_value = (led_red || led_ir) ? {led_ir, n_q} : ~{led_ir, n_q};
    end
    assign temp_value = TEMP_CODE;
    assign int_pin = int_n_oe ? int_n_o : 1'b1;
endmodule : ostirq_sense_model

// File: tb/ostirq_chk_assertions.sv
`timescale 1ns/1ps
module ostirq_chk
    import ostirq_pkg::*;
#(
    parameter int PW_CYC_0 = PW0_CYC, parameter int PW_CYC_1 = PW1_CYC,
    parameter int PW_CYC_2 = PW2_CYC, parameter int PW_CYC_3 = PW3_CYC,
    parameter int GAP_CYC_0 = GAP0_CYC, parameter int GAP_CYC_1 = GAP1_CYC,
    parameter int GAP_CYC_2 = GAP2_CYC, parameter int GAP_CYC_3 = GAP3_CYC,
    parameter int TEMP_CYC = TEMP_CONV_CYC
) (
    // Observed ports
    input  wire logic        CORE_CLK,
    input  wire logic        SRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic        LED_RED,
    input  wire logic        LED_IR,
    input  wire logic        INT_N_O,
    input  wire logic        INT_N_OE
);
    localparam int PWA [4] = '{PW_CYC_0, PW_CYC_1, PW_CYC_2, PW_CYC_3};
    localparam int GPA [4] = '{GAP_CYC_0, GAP_CYC_1, GAP_CYC_2, GAP_CYC_3};
    localparam int TLO = TEMP_CYC - 2;
    localparam int THI = TEMP_CYC + 4;
    logic [1:0]  pw_q, en_q;
    logic [2:0]  mode_q;
    logic [15:0] hi_q, e2e_q;
    logic        acc, rd;
    assign acc = PSEL && PENABLE;
    assign rd  = acc && !PWRITE;
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of written settings; mid-sample changes are not tracked
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            pw_q   <= 2'h0;
            en_q   <= 2'h0;
            mode_q <= 3'h0;
        end else if (acc && PWRITE) begin
            if (PADDR == OFS_CONFIG) pw_q <= PWDATA[1:0];
            if (PADDR == OFS_INT_ENABLE) en_q <= PWDATA[1:0];
            if (PADDR == OFS_MODE) mode_q <= PWDATA[2:0];
        end
    end
    // Lit-length and red-rise-to-now counters
    always_ff @(posedge CORE_CLK) begin
        hi_q  <= (LED_RED || LED_IR) ? hi_q + 16'h1 : 16'h0;
        e2e_q <= $rose(LED_RED) ? 16'h1 : e2e_q + 16'h1;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    a_led_exclusive: assert property (!(LED_RED && LED_IR))
        else $error("both LEDs lit");
    a_od_data_low: assert property (INT_N_O == 1'b0)
        else $error("open-drain data not low");
    a_pulse_width: assert property ($fell(LED_RED) || $fell(LED_IR) |-> hi_q == PWA[pw_q])
        else $error("pulse length wrong");
    a_edge_to_edge: assert property ($rose(LED_IR) && mode_q == MODE_OXI |-> e2e_q == PWA[pw_q] + GPA[pw_q])
        else $error("red to IR spacing wrong");
    a_status_clear: assert property (rd && PADDR == OFS_INT_STATUS |-> ##2 !INT_N_OE)
        else $error("status read left pin low");
    a_temp_irq: assert property (acc && PWRITE && PADDR == OFS_TEMP_CTRL && PWDATA[0] && en_q[1]
        |-> ##[TLO:THI] INT_N_OE)
        else $error("no temperature interrupt");
    a_temp_clear: assert property (rd && PADDR == OFS_TEMP_DATA && !en_q[0] |-> ##2 !INT_N_OE)
        else $error("temperature read left pin low");
    a_fifo_clear: assert property (rd && PADDR == OFS_FIFO_DATA && !en_q[1] |-> ##2 !INT_N_OE)
        else $error("FIFO read left pin low");
    a_pin_needs_en: assert property (INT_N_OE |-> $past(en_q) != 2'h0)
        else $error("pin low with no interrupt enabled");
endmodule : ostirq_chk
bind ostirq_top ostirq_chk #(.PW_CYC_0(PW_CYC_0), .PW_CYC_1(PW_CYC_1), .PW_CYC_2(PW_CYC_2),
    .PW_CYC_3(PW_CYC_3), .GAP_CYC_0(GAP_CYC_0), .GAP_CYC_1(GAP_CYC_1), .GAP_CYC_2(GAP_CYC_2),
    .GAP_CYC_3(GAP_CYC_3), .TEMP_CYC(TEMP_CYC)) ostirq_chk_inst (.CORE_CLK(CORE_CLK),
    .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .LED_RED(LED_RED), .LED_IR(LED_IR), .INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE));

// File: tb/optical_sample_timing_and_irq_tb.sv
`timescale 1ns/1ps
module optical_sample_timing_and_irq_tb;
    import ostirq_pkg::*;
    localparam logic [11:0] TEMP_CODE = 12'h5A3;
    // Shortened timing so every pulse width fits in one short run
    localparam int T_PW [4]  = '{5, 6, 7, 8};
    localparam int T_GAP [4] = '{10, 11, 12, 13};
    localparam int T_TEMP    = 20;
    localparam int T_WAIT    = 10;
    localparam logic [7:0]  RST_A [5] = '{OFS_MODE, OFS_CONFIG, OFS_INT_ENABLE, OFS_INT_STATUS,
                                          OFS_FIFO_COUNT};
    localparam logic [31:0] RST_V [5] = '{32'h0, 32'h1000, 32'h0, 32'h0, 32'h0};
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, led_red, led_ir, int_n_o, int_n_oe, int_pin;
    logic [SLOT_BITS-1:0] adc_value;
    logic [11:0] temp_value;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    // Free-running core clock
    initial forever #20 clk = ~clk;
    ostirq_top #(.PW_CYC_0(T_PW[0]), .PW_CYC_1(T_PW[1]), .PW_CYC_2(T_PW[2]),
        .PW_CYC_3(T_PW[3]), .GAP_CYC_0(T_GAP[0]), .GAP_CYC_1(T_GAP[1]), .GAP_CYC_2(T_GAP[2]),
        .GAP_CYC_3(T_GAP[3]), .TEMP_CYC(T_TEMP), .WAIT_CYC(T_WAIT))
        ostirq_top_inst (.CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .ADC_VALUE(adc_value), .TEMP_VALUE(temp_value), .LED_RED(led_red),
        .LED_IR(led_ir), .INT_N_O(int_n_o), .INT_N_OE(int_n_oe));
    ostirq_sense_model #(.TEMP_CODE(TEMP_CODE)) ostirq_sense_model_inst (.clk(clk),
        .srst(srst), .led_red(led_red), .led_ir(led_ir), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
        .int_pin(int_pin), .adc_value(adc_value), .temp_value(temp_value));
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; waits for pready, the bench timeout bounds it
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : acc
    task automatic reset();
        srst <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
    endtask : reset
    // Bounded wait for the pin to be pulled low
    task automatic wait_int();
        for (int k = 0; k < 2000 && int_pin !== 1'b0; k++) @(posedge clk);
        chk({31'h0, int_pin}, 32'h0);
    endtask : wait_int
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, RST_A[i], 32'h0);
            chk(r, RST_V[i]);
        end
        acc(1'b0, 8'h20, 32'h0);
        chk({err, r[30:0]}, 32'h80000000);
        // Oximetry at every pulse width, threshold 4
        for (int p = 0; p < 4; p++) begin
            reset();
            acc(1'b1, OFS_CONFIG, 32'h400 | p);
            acc(1'b1, OFS_INT_ENABLE, 32'h1);
            acc(1'b1, OFS_MODE, {29'h0, MODE_OXI});
            wait_int();
            acc(1'b0, OFS_FIFO_COUNT, 32'h0);
            chk(r, 32'h4);
            for (int j = 0; j < 8; j++) begin
                acc(1'b0, OFS_FIFO_DATA, 32'h0);
                chk(r, {14'h0, j[0], 17'(j + 1)});
            end
            chk({31'h0, int_pin}, 32'h1);
            wait_int();
            acc(1'b0, OFS_FIFO_DATA, 32'h0);
            chk(r, {14'h0, 1'b0, 17'd9});
        end
        // Heart-rate on infrared with almost-full masked
        reset();
        acc(1'b1, OFS_CONFIG, 32'h1004);
        acc(1'b1, OFS_MODE, {29'h0, MODE_HR});
        for (int k = 0; k < 400; k++) begin
            acc(1'b0, OFS_INT_STATUS, 32'h0);
            if (r[BIT_AFULL] === 1'b1) break;
        end
        acc(1'b0, OFS_FIFO_COUNT, 32'h0);
        chk(r, 32'h1F);
        chk({31'h0, int_pin}, 32'h1);
        repeat (80) @(posedge clk);
        acc(1'b0, OFS_FIFO_COUNT, 32'h0);
        chk(r, 32'h20);
        acc(1'b0, OFS_FIFO_DATA, 32'h0);
        chk(r, {14'h0, 1'b1, 17'd1});
        // Temperature conversions, enabled then masked
        // only three conversions, each well apart from the sample traffic
        reset();
        acc(1'b1, OFS_INT_ENABLE, 32'h2);
        acc(1'b1, OFS_TEMP_CTRL, 32'h1);
        acc(1'b0, OFS_TEMP_CTRL, 32'h0);
        chk(r, 32'h1);
        wait_int();
        acc(1'b0, OFS_TEMP_CTRL, 32'h0);
        chk(r, 32'h0);
        acc(1'b0, OFS_TEMP_DATA, 32'h0);
        chk(r, {20'h0, TEMP_CODE});
        repeat (2) @(posedge clk);
        chk({31'h0, int_pin}, 32'h1);
        acc(1'b1, OFS_TEMP_CTRL, 32'h1);
        wait_int();
        acc(1'b0, OFS_INT_STATUS, 32'h0);
        chk(r, 32'h2);
        acc(1'b0, OFS_INT_STATUS, 32'h0);
        chk(r, 32'h0);
        acc(1'b1, OFS_INT_ENABLE, 32'h0);
        acc(1'b1, OFS_TEMP_CTRL, 32'h1);
        repeat (40) @(posedge clk);
        chk({31'h0, int_pin}, 32'h1);
        acc(1'b0, OFS_INT_STATUS, 32'h0);
        chk(r, 32'h2);
        conclude();
    end
endmodule : optical_sample_timing_and_irq_tb
